//--- include/bpu_pkg.sv
`default_nettype none
package bpu_pkg;
    localparam int ADDR_W = 32;
    localparam int TGT_BUF_ENTRIES = 256;
    localparam int RAS_DEPTH = 16;
    localparam int FLUSH_CYCLES = 20;
    localparam int IDX_LSB = 2;
    localparam logic [1:0] CTR_RESET = 2'h1;
    localparam logic [1:0] CTR_MAX = 2'h3;
    localparam logic [1:0] CTR_MIN = 2'h0;
    localparam int CTR_TAKEN_BIT = 1;
    localparam logic [ADDR_W-1:0] RET_STEP = 32'h4;

    typedef enum logic [2:0] {
        XFER_NONE, XFER_COND, XFER_JUMP, XFER_CALL, XFER_RET, XFER_INDIRECT, XFER_FAR
    } xfer_kind_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] pc;
    } fetch_req_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] pc;
        xfer_kind_t kind;
        logic [ADDR_W-1:0] target;
        logic dispNeg;
        logic hintValid;
        logic hintTaken;
        logic traceBuild;
    } decode_info_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] pc;
        logic taken;
        logic [ADDR_W-1:0] target;
        logic mispredict;
    } retire_upd_t;

    typedef struct packed {
        logic valid;
        logic taken;
        logic [ADDR_W-1:0] target;
    } prediction_t;
endpackage
`default_nettype wire

//--- src/branch_prediction_unit.sv
`default_nettype none
module branch_prediction_unit #(
    parameter int ENTRIES = bpu_pkg::TGT_BUF_ENTRIES,
    parameter int RAS_N = bpu_pkg::RAS_DEPTH,
    parameter int FLUSH_N = bpu_pkg::FLUSH_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire bpu_pkg::fetch_req_t fetchReq,
    input wire bpu_pkg::decode_info_t decodeInfo,
    input wire bpu_pkg::retire_upd_t retireUpd,
    output bpu_pkg::prediction_t fetchPred,
    output bpu_pkg::prediction_t decodePred,
    output logic traceContinue,
    output logic flushYoung,
    output logic redirectValid,
    output logic [bpu_pkg::ADDR_W-1:0] redirectPc,
    output logic frontStall
);
    localparam int IW = $clog2(ENTRIES);
    localparam int SW = $clog2(RAS_N);
    localparam int FW = $clog2(FLUSH_N + 1);
    localparam int TW = bpu_pkg::ADDR_W - IW - bpu_pkg::IDX_LSB;

    initial begin
        if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0) begin
            $error("ENTRIES must be power of 2");
        end
        if (RAS_N < 2 || (RAS_N & (RAS_N - 1)) != 0) begin
            $error("RAS_N must be power of 2");
        end
        if (FLUSH_N < 1) begin
            $error("FLUSH_N must be positive");
        end
        if (IW + bpu_pkg::IDX_LSB >= bpu_pkg::ADDR_W) begin
            $error("ENTRIES too large for address width");
        end
    end

    function automatic logic [IW-1:0] idxOf(input logic [bpu_pkg::ADDR_W-1:0] a);
        return a[bpu_pkg::IDX_LSB +: IW];
    endfunction
    function automatic logic [TW-1:0] tagOf(input logic [bpu_pkg::ADDR_W-1:0] a);
        return a[bpu_pkg::ADDR_W-1 -: TW];
    endfunction

    logic entValid_r [ENTRIES];
    logic [TW-1:0] entTag_r [ENTRIES];
    logic [bpu_pkg::ADDR_W-1:0] entTgt_r [ENTRIES];
    logic [1:0] entCtr_r [ENTRIES];
    logic [bpu_pkg::ADDR_W-1:0] ras_r [RAS_N];
    logic [SW-1:0] rasTop_r;
    logic [FW-1:0] flushCnt_r;

    logic [IW-1:0] fIdx, dIdx, uIdx;
    logic fHit, dHit, uHit;
    logic dNear, isCall, isRet;
    logic [1:0] ctrNxt;
    logic misRetire;
    logic [SW-1:0] rasRdPtr;

    // entry hit test shared by fetch, decode and retire lookups
    function automatic logic hitAt(
        input logic [IW-1:0] i,
        input logic [bpu_pkg::ADDR_W-1:0] a
    );
        return entValid_r[i] && entTag_r[i] == tagOf(a);
    endfunction

    assign fIdx = idxOf(fetchReq.pc);
    assign dIdx = idxOf(decodeInfo.pc);
    assign uIdx = idxOf(retireUpd.pc);
    assign fHit = hitAt(fIdx, fetchReq.pc);
    assign dHit = hitAt(dIdx, decodeInfo.pc);
    assign uHit = hitAt(uIdx, retireUpd.pc);
    assign misRetire = retireUpd.valid && retireUpd.mispredict;
    assign rasRdPtr = rasTop_r - SW'(1);
    assign dNear = decodeInfo.valid && decodeInfo.kind != bpu_pkg::XFER_NONE
        && decodeInfo.kind != bpu_pkg::XFER_FAR;
    assign isCall = dNear && decodeInfo.kind == bpu_pkg::XFER_CALL;
    assign isRet = dNear && decodeInfo.kind == bpu_pkg::XFER_RET;

    // fetch-time dynamic prediction, same cycle as request
    always_comb begin
        fetchPred = '0;
        if (fetchReq.valid && fHit) begin
            fetchPred.valid = 1'b1;
            fetchPred.taken = entCtr_r[fIdx][bpu_pkg::CTR_TAKEN_BIT];
            fetchPred.target = entTgt_r[fIdx];
        end
    end

    // decode-time prediction
    always_comb begin
        decodePred = '0;
        if (dNear) begin
            decodePred.valid = 1'b1;
            decodePred.target = decodeInfo.target;
            case (decodeInfo.kind)
                bpu_pkg::XFER_RET: begin
                    decodePred.taken = 1'b1;
                    decodePred.target = ras_r[rasRdPtr];
                end
                bpu_pkg::XFER_JUMP, bpu_pkg::XFER_CALL: decodePred.taken = 1'b1;
                bpu_pkg::XFER_INDIRECT: begin
                    decodePred.taken = 1'b1;
                    decodePred.target = dHit ? entTgt_r[dIdx] : decodeInfo.target;
                end
                bpu_pkg::XFER_COND: begin
                    if (dHit) begin
                        decodePred.taken = entCtr_r[dIdx][bpu_pkg::CTR_TAKEN_BIT];
                        decodePred.target = entTgt_r[dIdx];
                    end else if (decodeInfo.hintValid && decodeInfo.traceBuild) begin
                        decodePred.taken = decodeInfo.hintTaken;
                    end else begin
                        decodePred.taken = decodeInfo.dispNeg;
                    end
                end
                default: decodePred.taken = 1'b0;
            endcase
        end
    end

    assign traceContinue = decodeInfo.traceBuild && decodePred.valid
        && decodePred.taken;

    always_comb begin
        ctrNxt = uHit ? entCtr_r[uIdx] : bpu_pkg::CTR_RESET;
        if (retireUpd.taken && ctrNxt != bpu_pkg::CTR_MAX) begin
            ctrNxt = ctrNxt + 2'h1;
        end else if (!retireUpd.taken && ctrNxt != bpu_pkg::CTR_MIN) begin
            ctrNxt = ctrNxt - 2'h1;
        end
    end

    // target buffer update at retirement
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < ENTRIES; i++) begin
                entValid_r[i] <= 1'b0;
                entTag_r[i] <= '0;
                entTgt_r[i] <= '0;
                entCtr_r[i] <= bpu_pkg::CTR_RESET;
            end
        end else if (retireUpd.valid) begin
            entValid_r[uIdx] <= 1'b1;
            entTag_r[uIdx] <= tagOf(retireUpd.pc);
            entCtr_r[uIdx] <= ctrNxt;
            if (retireUpd.taken) begin
                entTgt_r[uIdx] <= retireUpd.target;
            end
        end
    end

    // return stack, circular on overflow
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rasTop_r <= '0;
            for (int i = 0; i < RAS_N; i++) begin
                ras_r[i] <= '0;
            end
        end else if (!frontStall) begin
            if (isCall) begin
                ras_r[rasTop_r] <= decodeInfo.pc + bpu_pkg::RET_STEP;
                rasTop_r <= rasTop_r + SW'(1);
            end else if (isRet) begin
                rasTop_r <= rasTop_r - SW'(1);
            end
        end
    end

    // misprediction recovery window
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flushCnt_r <= '0;
        end else if (misRetire) begin
            flushCnt_r <= FW'(FLUSH_N);
        end else if (flushCnt_r != '0) begin
            flushCnt_r <= flushCnt_r - FW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            redirectValid <= 1'b0;
            flushYoung <= 1'b0;
        end else begin
            redirectValid <= misRetire;
            flushYoung <= misRetire;
        end
    end

    // corrected fetch address
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            redirectPc <= '0;
        end else begin
            if (misRetire) begin
                redirectPc <= retireUpd.taken ? retireUpd.target
                    : retireUpd.pc + bpu_pkg::RET_STEP;
            end
        end
    end

    assign frontStall = flushCnt_r != '0;
endmodule // branch_prediction_unit
`default_nettype wire

//--- dv/bpu_checker_props.sv
`default_nettype none
module bpu_checker #(parameter int FLUSH_N = 2) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire bpu_pkg::decode_info_t decodeInfo,
    input wire bpu_pkg::retire_upd_t retireUpd,
    input wire bpu_pkg::prediction_t decodePred,
    input wire logic traceContinue,
    input wire logic flushYoung,
    input wire logic redirectValid,
    input wire logic [bpu_pkg::ADDR_W-1:0] redirectPc,
    input wire logic frontStall
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mr;
    logic dv;
    bpu_pkg::xfer_kind_t kd;
    assign mr = retireUpd.valid && retireUpd.mispredict;
    assign dv = decodeInfo.valid;
    assign kd = decodeInfo.kind;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    near_pred_a: assert property (
        dv && !(kd inside {bpu_pkg::XFER_NONE, bpu_pkg::XFER_FAR}) |-> decodePred.valid)
        else $error("near transfer not predicted");
    far_skip_a: assert property (dv && kd == bpu_pkg::XFER_FAR |-> !decodePred.valid)
        else $error("far transfer predicted");
    ret_taken_a: assert property (dv && kd == bpu_pkg::XFER_RET |-> decodePred.taken)
        else $error("return not taken");
    trace_cont_a: assert property (
        dv && decodeInfo.traceBuild && decodePred.valid && decodePred.taken |-> traceContinue)
        else $error("trace stopped at taken branch");
    flush_pulse_a: assert property (
        mr ##1 !mr |-> flushYoung && redirectValid ##1 !flushYoung)
        else $error("flush pulse wrong");
    redir_pc_a: assert property (mr |=> redirectPc == ($past(retireUpd.taken) ?
        $past(retireUpd.target) : $past(retireUpd.pc) + 32'h4))
        else $error("redirect address wrong");
    stall_len_a: assert property (mr |=> frontStall [*2])
        else $error("stall too short");
    stall_end_a: assert property (mr ##1 !mr [*3] |-> !frontStall)
        else $error("stall too long");
    cover property (mr);
    cover property (traceContinue);
    cover property (frontStall ##1 !frontStall);
endmodule // bpu_checker
`default_nettype wire

//--- dv/retire_model.sv
`default_nettype none
module retire_model (
    input wire logic core_clk,
    input wire logic fire,
    input wire logic [31:0] rPc,
    input wire logic [31:0] rTgt,
    output bpu_pkg::retire_upd_t retireUpd
);
    timeunit 1ns;
    timeprecision 1ps;
    // one-cycle resolved mispredict, idle fields scrambled
    always_ff @(posedge core_clk) begin
        retireUpd <= fire ? '{1'b1, rPc, 1'b1, rTgt, 1'b1} : '{1'b0, ~rPc, 1'b0, ~rTgt, 1'b0};
    end
endmodule // retire_model
`default_nettype wire

//--- dv/branch_prediction_unit_tb.sv
`default_nettype none
module branch_prediction_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0;
    logic sys_rst = 1;
    logic fire = 0;
    logic [31:0] rPc = '0;
    logic [31:0] rTgt = '0;
    bpu_pkg::fetch_req_t fetchReq = '0;
    bpu_pkg::decode_info_t decodeInfo = '0;
    bpu_pkg::retire_upd_t retireUpd;
    bpu_pkg::prediction_t fetchPred, decodePred, s, ex, q[$];
    logic traceContinue, flushYoung, redirectValid, frontStall;
    logic [31:0] redirectPc, p, t, cs[$];
    int num_errors = 0;
    int tests_run = 0;
    always #2 core_clk = ~core_clk;
    retire_model u_ret (.core_clk, .fire, .rPc, .rTgt, .retireUpd);
    branch_prediction_unit #(.FLUSH_N(2)) u_dut (.core_clk, .sys_rst, .fetchReq, .decodeInfo,
        .retireUpd, .fetchPred, .decodePred, .traceContinue, .flushYoung, .redirectValid,
        .redirectPc, .frontStall);
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic dec(input bpu_pkg::xfer_kind_t k, input logic [3:0] f,
            input bpu_pkg::prediction_t e);
        #1 decodeInfo = '{1'b1, p, k, t, f[3], f[2], f[1], f[0]};
        q.push_back(e);
        @(posedge core_clk);
    endtask
    always @(negedge core_clk) begin
        s = '{decodePred.valid, decodePred.taken, decodePred.taken ? decodePred.target : 32'h0};
        if (fetchReq.valid) s = '{fetchPred.valid, fetchPred.taken, fetchPred.target};
        if (redirectValid) s = '{1'b1, 1'b1, redirectPc};
        if (q.size() > 0 && (redirectValid || fetchReq.valid || decodeInfo.valid)) begin
            tests_run++;
            if (s !== q[0]) begin
                num_errors++;
                $display("unexpected prediction: expected %h seen %h", q[0], s);
            end
            void'(q.pop_front());
        end
    end
    initial begin
        void'($urandom(32'h74EF));
        repeat (4) @(posedge core_clk);
        #1 sys_rst = 0;
        @(posedge core_clk);
        p = $urandom & 32'hFFFF_FFFC;
        for (int k = 0; k < 7; k++) begin
            t = $urandom;
            ex.valid = k > 0 && k < 6;
            ex.taken = k > 1 && k < 6;
            ex.target = k == 4 ? p + 32'h4 : (ex.taken ? t : 32'h0);
            dec(bpu_pkg::xfer_kind_t'(k), 4'h0, ex);
        end
        dec(bpu_pkg::XFER_COND, 4'h8, '{1'b1, 1'b1, t});
        dec(bpu_pkg::XFER_COND, 4'hC, '{1'b1, 1'b1, t});
        dec(bpu_pkg::XFER_COND, 4'hD, '{1'b1, 1'b0, 32'h0});
        dec(bpu_pkg::XFER_COND, 4'h7, '{1'b1, 1'b1, t});
        dec(bpu_pkg::XFER_COND, 4'h6, '{1'b1, 1'b0, 32'h0});
        for (int i = 0; i < 16; i++) begin
            p = ($urandom & 32'hFFFF_F000) + 32'h40 * i;
            cs.push_back(p);
            dec(bpu_pkg::XFER_CALL, 4'h0, '{1'b1, 1'b1, t});
        end
        for (int i = 0; i < 16; i++) begin
            dec(bpu_pkg::XFER_RET, 4'h0, '{1'b1, 1'b1, cs.pop_back() + 32'h4});
        end
        #1 decodeInfo = '0;
        p = $urandom & 32'hFFFF_FFFC;
        t = $urandom;
        rPc = p;
        rTgt = t;
        fire = 1;
        q.push_back('{1'b1, 1'b1, t});
        @(posedge core_clk);
        #1 fire = 0;
        for (int i = 0; i < 40 && (frontStall !== 1'b0 || i < 3); i++) begin
            @(posedge core_clk);
            #1;
        end
        if (frontStall !== 1'b0) begin
            num_errors++;
            $display("unexpected frontStall: expected 0 seen %b", frontStall);
            end_of_test();
        end
        fetchReq = '{1'b1, p};
        q.push_back('{1'b1, 1'b1, t});
        @(posedge core_clk);
        #1 fetchReq = '0;
        repeat (2) @(posedge core_clk);
        if (q.size() != 0) begin
            num_errors++;
            $display("unexpected queue depth: expected 0 seen %0d", q.size());
        end
        end_of_test();
    end
endmodule // branch_prediction_unit_tb
bind branch_prediction_unit bpu_checker #(.FLUSH_N(FLUSH_N)) u_chk (.core_clk, .sys_rst,
    .decodeInfo, .retireUpd, .decodePred, .traceContinue, .flushYoung, .redirectValid,
    .redirectPc, .frontStall);
`default_nettype wire
